// ---- rtl/eoc_regs.svh ----
// Purpose: constants of the external oscillator control block
// Assumes: 125 MHz sys_clk, AXI4-Lite register access, one word per register
// Notes:   indices are register numbers; byte address is four times the index
//
// Summary of operation
// - mode codes 000 and 001 keep the oscillator drive off, no clock out.
// - mode 010 passes the CMOS clock input, 011 adds divide-by-two.
// - mode 100 is RC with divide-by-two, 101 capacitor with divide-by-two.
// - mode 110 is crystal undivided, 111 crystal with divide-by-two.
// - every divide-by-two mode delivers a clock of 50 percent duty.
// - bit 7 is a read-only valid flag, 1 once the clock runs stably.
// - bit 3 always reads zero and ignores writes.
`ifndef EOC_REGS_SVH
`define EOC_REGS_SVH

`define EOC_ADDR_W        12
// register indices and byte addresses
`define EOC_CTRL_IDX      12'h0b1
`define EOC_IRQ_STAT_IDX  12'h0b2
`define EOC_IRQ_MASK_IDX  12'h0b3
`define EOC_CTRL_ADDR     (`EOC_CTRL_IDX * 12'h004)
`define EOC_STAT_ADDR     (`EOC_IRQ_STAT_IDX * 12'h004)
`define EOC_MASK_ADDR     (`EOC_IRQ_MASK_IDX * 12'h004)

// control register fields
`define EOC_VALID_BIT     7
`define EOC_MODE_MSB      6
`define EOC_MODE_LSB      4
`define EOC_UNUSED_BIT    3
`define EOC_FREQ_MSB      2
`define EOC_FREQ_LSB      0
`define EOC_CTRL_RESET    8'h00

// interrupt status fields
`define EOC_IRQ_ROSE_BIT  0
`define EOC_IRQ_FELL_BIT  1
`define EOC_IRQ_RESET     2'h0

// valid detector timing
`define EOC_CLK_PERIOD_NS 8
`define EOC_STALL_NS      10000
`define EOC_STALL_CYC     ((`EOC_STALL_NS + `EOC_CLK_PERIOD_NS - 1) / `EOC_CLK_PERIOD_NS)
`define EOC_VALID_EDGES   16

`define EOC_RESP_OKAY     2'h0
`define EOC_RESP_SLVERR   2'h2

`endif

// ---- rtl/eoc_pkg.sv ----
// Purpose: types of the external oscillator control block
// Assumes: constants come from eoc_regs.svh
// Notes:   state of each module is one packed struct
`include "eoc_regs.svh"

package eoc_pkg;

   typedef enum logic [2:0] {
      EOC_OFF_A     = 3'b000,
      EOC_OFF_B     = 3'b001,
      EOC_CMOS      = 3'b010,
      EOC_CMOS_DIV2 = 3'b011,
      EOC_RC_DIV2   = 3'b100,
      EOC_CAP_DIV2  = 3'b101,
      EOC_XTAL      = 3'b110,
      EOC_XTAL_DIV2 = 3'b111
   } eoc_mode_t;

   typedef struct packed {
      logic       rawPrev;
      logic       half;
      logic       clkOut;
   } eoc_div_state_t;

   typedef struct packed {
      logic                    awHeld;
      logic [`EOC_ADDR_W-1:0]  awAddr;
      logic                    wHeld;
      logic [7:0]              wData;
      logic                    wLane0;
      logic                    bValid;
      logic [1:0]              bResp;
      logic                    rValid;
      logic [7:0]              rData;
      logic [1:0]              rResp;
      eoc_mode_t               mode;
      logic [2:0]              freq;
      logic                    valid;
      logic [4:0]              edgeCnt;
      logic [10:0]             gapCnt;
      logic [1:0]              irqStat;
      logic [1:0]              irqMask;
      logic                    irq;
      logic                    driveEn;
      logic                    xtalEn;
      logic                    rcEn;
      logic                    capEn;
      logic                    cmosEn;
   } eoc_state_t;

endpackage

// ---- rtl/eoc_clk_div.sv ----
// Purpose: edge detect and optional divide-by-two of the raw oscillation
// Assumes: rawIn is synchronous to sys_clk and well below half its rate
// Notes:   the halved output toggles on rising edges only, so duty is 50%
`timescale 1ns/10ps

module eoc_clk_div (
   input  wire logic sys_clk,
   input  wire logic arst_n,
   input  wire logic rawIn,
   input  wire logic enable,
   input  wire logic halve,
   output logic      clkOut,
   output logic      rawRise
);

   eoc_pkg::eoc_div_state_t q;
   eoc_pkg::eoc_div_state_t n;

   // rising edge of the sampled raw oscillation
   assign rawRise = enable & rawIn & ~q.rawPrev;
   assign clkOut  = q.clkOut;

   // next state: pass through or toggle per raw period
   always_comb begin
      n = q;
      n.rawPrev = rawIn;
      if (!enable) begin
         n.half   = 1'b0;
         n.clkOut = 1'b0;
      end else if (halve) begin
         // raw duty is irrelevant: one toggle per period
         if (rawIn && !q.rawPrev) begin
            n.half = ~q.half;
         end
         n.clkOut = n.half;
      end else begin
         n.half   = 1'b0;
         n.clkOut = rawIn;
      end
   end

   // state register
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         q <= '0;
      end else begin
         q <= n;
      end
   end

endmodule

// ---- rtl/eoc_ctrl.sv ----
// Purpose: external oscillator control register, mode decode and valid detector
// Assumes: AXI4-Lite master keeps one write and one read outstanding at most
// Notes:   analog drive circuit lives outside; this block steers its enables
//
// The AXI4-Lite slave port was left to the implementer.
`timescale 1ns/10ps
`include "eoc_regs.svh"

module eoc_ctrl (
   input  wire logic                   sys_clk,
   input  wire logic                   arst_n,
   // AXI4-Lite slave
   input  wire logic [`EOC_ADDR_W-1:0] s_axi_awaddr,
   input  wire logic                   s_axi_awvalid,
   output logic                        s_axi_awready,
   input  wire logic [31:0]            s_axi_wdata,
   input  wire logic [3:0]             s_axi_wstrb,
   input  wire logic                   s_axi_wvalid,
   output logic                        s_axi_wready,
   output logic [1:0]                  s_axi_bresp,
   output logic                        s_axi_bvalid,
   input  wire logic                   s_axi_bready,
   input  wire logic [`EOC_ADDR_W-1:0] s_axi_araddr,
   input  wire logic                   s_axi_arvalid,
   output logic                        s_axi_arready,
   output logic [31:0]                 s_axi_rdata,
   output logic [1:0]                  s_axi_rresp,
   output logic                        s_axi_rvalid,
   input  wire logic                   s_axi_rready,
   // oscillator side
   input  wire logic                   oscillatorPinTwo,
   output logic                        oscDriveEn,
   output logic                        crystalAmpEn,
   output logic                        rcOscEn,
   output logic                        capOscEn,
   output logic                        cmosInEn,
   output logic [2:0]                  extOscFrequencyRange,
   output logic                        extOscClk,
   output logic                        extClockValidFlag,
   output logic                        irq
);

   eoc_pkg::eoc_state_t q;
   eoc_pkg::eoc_state_t n;

   logic rawRise;
   logic divClk;
   logic halveSel;
   logic doWrite;
   logic wrCtrl;
   logic wrStat;
   logic wrMask;
   logic [1:0] irqSet;
   logic [1:0] irqClr;

   // divide-by-two in every odd mode code and in the rc mode
   assign halveSel = q.mode[0] | (q.mode == eoc_pkg::EOC_RC_DIV2);

   // raw oscillation edges and derived clock
   eoc_clk_div uDiv (
      .sys_clk (sys_clk),
      .arst_n  (arst_n),
      .rawIn   (oscillatorPinTwo),
      .enable  (q.driveEn),
      .halve   (halveSel),
      .clkOut  (divClk),
      .rawRise (rawRise)
   );

   // bus handshakes: one write and one read at a time
   assign s_axi_awready = ~q.awHeld & ~q.bValid;
   assign s_axi_wready  = ~q.wHeld & ~q.bValid;
   assign s_axi_arready = ~q.rValid;
   assign s_axi_bvalid  = q.bValid;
   assign s_axi_bresp   = q.bResp;
   assign s_axi_rvalid  = q.rValid;
   assign s_axi_rresp   = q.rResp;
   assign s_axi_rdata   = {24'h000000, q.rData};

   // oscillator side outputs, all from flip-flops
   assign oscDriveEn           = q.driveEn;
   assign crystalAmpEn         = q.xtalEn;
   assign rcOscEn              = q.rcEn;
   assign capOscEn             = q.capEn;
   assign cmosInEn             = q.cmosEn;
   assign extOscFrequencyRange = q.freq;
   assign extOscClk            = divClk;
   assign extClockValidFlag    = q.valid;
   assign irq                  = q.irq;

   // write fires once both address and data are held
   assign doWrite = q.awHeld & q.wHeld & ~q.bValid;
   assign wrCtrl  = doWrite & q.wLane0 & (q.awAddr == `EOC_CTRL_ADDR);
   assign wrStat  = doWrite & q.wLane0 & (q.awAddr == `EOC_STAT_ADDR);
   assign wrMask  = doWrite & q.wLane0 & (q.awAddr == `EOC_MASK_ADDR);

   // read value of a register; unknown addresses answer with an error
   function automatic logic [9:0] readReg(input logic [`EOC_ADDR_W-1:0] addr,
                                          input eoc_pkg::eoc_state_t   s);
      logic [9:0] r;
      r = {`EOC_RESP_OKAY, 8'h00};
      if (addr == `EOC_CTRL_ADDR) begin
         // bit 3 wired to zero, valid flag on bit 7
         r[7:0] = {s.valid, s.mode, 1'b0, s.freq};
      end else if (addr == `EOC_STAT_ADDR) begin
         r[7:0] = {6'h00, s.irqStat};
      end else if (addr == `EOC_MASK_ADDR) begin
         r[7:0] = {6'h00, s.irqMask};
      end else begin
         r = {`EOC_RESP_SLVERR, 8'h00};
      end
      return r;
   endfunction

   // next state of bus, register file, detector and interrupt
   always_comb begin
      logic [9:0] rd;
      rd = 10'h000;
      n = q;
      irqSet = 2'h0;
      irqClr = 2'h0;

      // write address and data may arrive in either order
      if (s_axi_awvalid && s_axi_awready) begin
         n.awHeld = 1'b1;
         n.awAddr = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         n.wHeld  = 1'b1;
         n.wData  = s_axi_wdata[7:0];
         n.wLane0 = s_axi_wstrb[0];
      end
      if (q.bValid && s_axi_bready) begin
         n.bValid = 1'b0;
      end
      if (doWrite) begin
         n.awHeld = 1'b0;
         n.wHeld  = 1'b0;
         n.bValid = 1'b1;
         if ((q.awAddr == `EOC_CTRL_ADDR) || (q.awAddr == `EOC_STAT_ADDR) ||
             (q.awAddr == `EOC_MASK_ADDR)) begin
            n.bResp = `EOC_RESP_OKAY;
         end else begin
            n.bResp = `EOC_RESP_SLVERR;
         end
      end

      // control write: bits 7 and 3 are dropped
      if (wrCtrl) begin
         n.mode = eoc_pkg::eoc_mode_t'(q.wData[`EOC_MODE_MSB:`EOC_MODE_LSB]);
         n.freq = q.wData[`EOC_FREQ_MSB:`EOC_FREQ_LSB];
      end
      if (wrMask) begin
         n.irqMask = q.wData[1:0];
      end
      if (wrStat) begin
         irqClr = q.wData[1:0];
      end

      // reads answer one cycle after the address is taken
      if (q.rValid && s_axi_rready) begin
         n.rValid = 1'b0;
      end
      if (s_axi_arvalid && s_axi_arready) begin
         rd = readReg(s_axi_araddr, q);
         n.rValid = 1'b1;
         n.rResp  = rd[9:8];
         n.rData  = rd[7:0];
      end

      // drive circuit enables follow the mode code
      n.driveEn = 1'b1;
      n.xtalEn  = 1'b0;
      n.rcEn    = 1'b0;
      n.capEn   = 1'b0;
      n.cmosEn  = 1'b0;
      unique case (n.mode)
         eoc_pkg::EOC_OFF_A,
         eoc_pkg::EOC_OFF_B: begin
            n.driveEn = 1'b0;
         end
         eoc_pkg::EOC_CMOS,
         eoc_pkg::EOC_CMOS_DIV2: begin
            n.cmosEn = 1'b1;
         end
         eoc_pkg::EOC_RC_DIV2: begin
            n.rcEn = 1'b1;
         end
         eoc_pkg::EOC_CAP_DIV2: begin
            n.capEn = 1'b1;
         end
         eoc_pkg::EOC_XTAL,
         eoc_pkg::EOC_XTAL_DIV2: begin
            n.xtalEn = 1'b1;
         end
      endcase

      // valid detector: enough edges with no long gap
      // a mode change restarts the count, since the old clock says nothing
      if (!q.driveEn || (n.mode != q.mode)) begin
         n.valid   = 1'b0;
         n.edgeCnt = 5'h00;
         n.gapCnt  = 11'h000;
      end else if (rawRise) begin
         n.gapCnt = 11'h000;
         if (q.edgeCnt == 5'(`EOC_VALID_EDGES - 1)) begin
            n.valid = 1'b1;
         end else begin
            n.edgeCnt = q.edgeCnt + 5'h01;
         end
      end else if (q.gapCnt == 11'(`EOC_STALL_CYC - 1)) begin
         // oscillation stopped: the clock is no longer trustworthy
         n.valid   = 1'b0;
         n.edgeCnt = 5'h00;
         n.gapCnt  = 11'h000;
      end else begin
         n.gapCnt = q.gapCnt + 11'h001;
      end

      // sticky events; a set in the clear cycle wins
      irqSet[`EOC_IRQ_ROSE_BIT] = n.valid & ~q.valid;
      irqSet[`EOC_IRQ_FELL_BIT] = ~n.valid & q.valid;
      n.irqStat = (q.irqStat & ~irqClr) | irqSet;
      n.irq     = |(n.irqStat & n.irqMask);
   end

   // state register; reset clears the control register
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         q         <= '0;
         q.mode    <= eoc_pkg::eoc_mode_t'(3'(`EOC_CTRL_RESET >> `EOC_MODE_LSB));
         q.freq    <= 3'(`EOC_CTRL_RESET);
         q.irqStat <= `EOC_IRQ_RESET;
         q.irqMask <= `EOC_IRQ_RESET;
      end else begin
         q <= n;
      end
   end

endmodule

// ---- bench/eoc_osc_model.sv ----
// Purpose: behavioural oscillation source on the second oscillator pin
// Assumes: period is a whole number of sys_clk cycles
// Notes:   stalls on request so the loss-of-clock path can be reached
`timescale 1ns/10ps

module eoc_osc_model (
   input  wire logic       sys_clk,
   input  wire logic       arst_n,
   input  wire logic       run,
   input  wire logic [7:0] halfCyc,
   output logic            pinOut
);
   logic [7:0] cnt_reg;

   // oscillates only while drive is on; a stopped pin flips once, then holds there
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         cnt_reg <= 8'h00;
         pinOut  <= 1'b0;
      end else if (!run) begin
         if (cnt_reg != 8'hff) pinOut <= ~pinOut;
         cnt_reg <= 8'hff;
      end else if (cnt_reg >= halfCyc - 8'h01) begin
         cnt_reg <= 8'h00;
         pinOut  <= ~pinOut;
      end else begin
         cnt_reg <= cnt_reg + 8'h01;
      end
   end
endmodule

// ---- bench/eoc_ctrl_assertions.sv ----
// Purpose: port-level checks of the external oscillator control block
// Assumes: single sys_clk domain, asynchronous active-low reset
// Notes:   duty check needs a steady pin period while halving
`timescale 1ns/10ps

module eoc_ctrl_assertions (
   input wire logic        sys_clk,
   input wire logic        arst_n,
   input wire logic        oscillatorPinTwo,
   input wire logic        s_axi_rvalid,
   input wire logic [31:0] s_axi_rdata,
   input wire logic        oscDriveEn,
   input wire logic        crystalAmpEn,
   input wire logic        rcOscEn,
   input wire logic        capOscEn,
   input wire logic        cmosInEn,
   input wire logic [2:0]  extOscFrequencyRange,
   input wire logic        extOscClk,
   input wire logic        extClockValidFlag,
   input wire logic        irq
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!arst_n);

   logic       prevClk_reg;
   logic [7:0] ivCnt_reg;
   logic [7:0] lastIv_reg;
   logic [1:0] togs_reg;
   wire        halving = rcOscEn | capOscEn;

   // interval between halved-clock toggles; first two ignored, entry glitch and phase are arbitrary
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         prevClk_reg <= 1'b0;
         ivCnt_reg   <= 8'h00;
         lastIv_reg  <= 8'h00;
         togs_reg    <= 2'h0;
      end else begin
         prevClk_reg <= extOscClk;
         if (!halving) begin
            ivCnt_reg <= 8'h00;
            togs_reg  <= 2'h0;
         end else if (extOscClk != prevClk_reg) begin
            lastIv_reg <= ivCnt_reg;
            ivCnt_reg  <= 8'h01;
            if (togs_reg != 2'h3) togs_reg <= togs_reg + 2'h1;
         end else begin
            ivCnt_reg <= ivCnt_reg + 8'h01;
         end
      end
   end

   sequence s_drive_gone;
      $fell(oscDriveEn);
   endsequence

   property p_off_quiet;
      !oscDriveEn |-> !(crystalAmpEn | rcOscEn | capOscEn | cmosInEn);
   endproperty
   property p_drive_any;
      oscDriveEn |-> (crystalAmpEn | rcOscEn | capOscEn | cmosInEn);
   endproperty
   property p_one_mode;
      oscDriveEn |-> $onehot({crystalAmpEn, rcOscEn, capOscEn, cmosInEn});
   endproperty
   property p_half_duty;
      halving && (extOscClk != prevClk_reg) && (togs_reg == 2'h3) |-> ivCnt_reg == lastIv_reg;
   endproperty
   property p_half_on_rise;
      halving && $past(halving) && $past(halving, 2) && $changed(extOscClk)
         |-> $past(oscillatorPinTwo) && !$past(oscillatorPinTwo, 2);
   endproperty
   property p_valid_needs_drive;
      $rose(extClockValidFlag) |-> oscDriveEn;
   endproperty
   property p_valid_drops;
      s_drive_gone |-> ##[0:2] !extClockValidFlag;
   endproperty
   property p_unused_zero;
      s_axi_rvalid |-> s_axi_rdata[3] == 1'b0 && s_axi_rdata[31:8] == 24'h000000;
   endproperty
   property p_reset_clear;
      disable iff (1'b0) !arst_n && $past(!arst_n)
         |-> !oscDriveEn && !extClockValidFlag && !irq && extOscFrequencyRange == 3'h0;
   endproperty

   a_off_quiet:         assert property (p_off_quiet) else $error("drive off but a mode enable is high");
   a_drive_any:         assert property (p_drive_any) else $error("drive on without a mode enable");
   a_one_mode:          assert property (p_one_mode) else $error("mode enables not one-hot");
   a_half_duty:         assert property (p_half_duty) else $error("halved clock interval changed");
   a_half_on_rise:      assert property (p_half_on_rise) else $error("halved clock moved off a pin rise");
   a_valid_needs_drive: assert property (p_valid_needs_drive) else $error("valid set with drive off");
   a_valid_drops:       assert property (p_valid_drops) else $error("valid kept after drive off");
   a_unused_zero:       assert property (p_unused_zero) else $error("unused read bits not zero");
   a_reset_clear:       assert property (p_reset_clear) else $error("outputs not cleared in reset");
endmodule

// ---- bench/external_oscillator_control_tb.sv ----
// Purpose: self-checking bench of the external oscillator control block
// Assumes: AXI4-Lite master, one transfer at a time, pin model period in cycles
// Notes:   mode rows first, then valid, stall, halving, unmapped, reset cases
`timescale 1ns/10ps
`include "eoc_regs.svh"

module external_oscillator_control_tb;
   logic        sys_clk, arst_n, oscRun, oscillatorPinTwo;
   logic [11:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata, rd;
   logic [3:0]  s_axi_wstrb;
   logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
   logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
   logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic        oscDriveEn, crystalAmpEn, rcOscEn, capOscEn, cmosInEn, extOscClk, extClockValidFlag, irq;
   logic [2:0]  extOscFrequencyRange;
   logic [7:0]  halfCyc;
   int          num_errors, comparisons, cycles;
   // control byte written (bit 3 set) beside enables {drive, crystal, rc, cap, cmos}
   logic [12:0] rows [8] = '{13'h1a0, 13'h340, 13'h571, 13'h791, 13'h9b4, 13'hbd2, 13'hdf8, 13'hf18};

   eoc_ctrl uut (.sys_clk, .arst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
      .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
      .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .oscillatorPinTwo, .oscDriveEn,
      .crystalAmpEn, .rcOscEn, .capOscEn, .cmosInEn, .extOscFrequencyRange, .extOscClk, .extClockValidFlag, .irq);
   eoc_osc_model osc (.sys_clk, .arst_n, .run(oscRun & oscDriveEn), .halfCyc, .pinOut(oscillatorPinTwo));

   // free-running 125 MHz clock
   initial begin
      sys_clk = 1'b0;
      forever #4 sys_clk = ~sys_clk;
   end

   task automatic chkVal(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         num_errors++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask

   // address and data go out together; each valid drops once taken, then the response is kept
   task automatic axw(input logic [11:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge sys_clk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid);
      resp = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask

   task automatic axr(input logic [11:0] a);
      @(posedge sys_clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge sys_clk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid);
      rd = s_axi_rdata;
      resp = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask

   task automatic results;
      if (num_errors == 0 && comparisons > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   // hang guard, well above the roughly 1600 cycles the sequence needs
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 20000) begin
         num_errors++;
         $display("[FAIL] %0t timeout", $time);
         results;
      end
   end

   initial begin
      {arst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
      s_axi_wstrb = 4'hf;
      halfCyc = 8'h03;
      oscRun = 1'b1;
      repeat (8) @(posedge sys_clk);
      arst_n <= 1'b1;
      axr(`EOC_CTRL_ADDR);
      chkVal(rd, 32'h0);
      axr(`EOC_MASK_ADDR);
      chkVal(rd, 32'h0);
      foreach (rows[i]) begin
         axw(`EOC_CTRL_ADDR, {24'h0, rows[i][12:5]});
         axr(`EOC_CTRL_ADDR);
         chkVal(rd, {24'h0, rows[i][12:5] & 8'h77});
         chkVal({oscDriveEn, crystalAmpEn, rcOscEn, capOscEn, cmosInEn}, rows[i][4:0]);
         chkVal(extOscFrequencyRange, rows[i][7:5]);
      end
      // crystal start: pin already running from the mode 111 row, unmask, switch to 110, then wait for the valid flag
      axw(`EOC_MASK_ADDR, 32'h3);
      axw(`EOC_CTRL_ADDR, 32'h65);
      for (int k = 0; k < 400 && !extClockValidFlag; k++) @(posedge sys_clk);
      @(posedge sys_clk);
      chkVal(irq, 1'b1);
      axr(`EOC_CTRL_ADDR);
      chkVal(rd, 32'he5);
      axr(`EOC_STAT_ADDR);
      chkVal(rd, 32'h1);
      axw(`EOC_STAT_ADDR, 32'h1);
      axr(`EOC_STAT_ADDR);
      chkVal(rd, 32'h0);
      chkVal(irq, 1'b0);
      // oscillation lost: flag falls, event raised, then masked away
      oscRun <= 1'b0;
      repeat (1300) @(posedge sys_clk);
      chkVal(extClockValidFlag, 1'b0);
      chkVal(irq, 1'b1);
      axw(`EOC_MASK_ADDR, 32'h0);
      axr(`EOC_STAT_ADDR);
      chkVal(rd, 32'h2);
      chkVal(irq, 1'b0);
      // rc halving mode runs long enough for the duty check
      oscRun <= 1'b1;
      axw(`EOC_CTRL_ADDR, 32'hcb);
      repeat (60) @(posedge sys_clk);
      axr(12'h000);
      chkVal(resp, `EOC_RESP_SLVERR);
      axw(12'h000, 32'hff);
      chkVal(resp, `EOC_RESP_SLVERR);
      axr(`EOC_CTRL_ADDR);
      chkVal(rd, 32'h43);
      axw(`EOC_CTRL_ADDR, 32'h05);
      axr(`EOC_CTRL_ADDR);
      chkVal({oscDriveEn, extClockValidFlag}, 2'h0);
      // lane 0 strobe low: the write is answered but leaves the register alone
      s_axi_wstrb <= 4'he;
      axw(`EOC_CTRL_ADDR, 32'h67);
      s_axi_wstrb <= 4'hf;
      chkVal(resp, `EOC_RESP_OKAY);
      axr(`EOC_CTRL_ADDR);
      chkVal(rd, 32'h05);
      // reset in mid-run clears everything
      axw(`EOC_CTRL_ADDR, 32'h67);
      arst_n <= 1'b0;
      repeat (2) @(posedge sys_clk);
      chkVal({oscDriveEn, extOscFrequencyRange}, 4'h0);
      arst_n <= 1'b1;
      axr(`EOC_CTRL_ADDR);
      chkVal(rd, 32'h0);
      results;
   end
endmodule

bind eoc_ctrl eoc_ctrl_assertions chk (.sys_clk, .arst_n, .oscillatorPinTwo, .s_axi_rvalid, .s_axi_rdata, .oscDriveEn,
   .crystalAmpEn, .rcOscEn, .capOscEn, .cmosInEn, .extOscFrequencyRange, .extOscClk, .extClockValidFlag, .irq);
